// File: mie_regs.svh
// register offsets, field positions, reset values, encodings and timing counts
`ifndef MIE_REGS_SVH
`define MIE_REGS_SVH

// register byte offsets on the bus
`define MIE_OFF_CTRL 8'h00
`define MIE_OFF_ACC 8'h04
`define MIE_OFF_FLAGS 8'h08
`define MIE_OFF_PC 8'h0c
`define MIE_OFF_INSTR 8'h10
`define MIE_OFF_STATUS 8'h14

// control and status field positions
`define MIE_CTRL_RUN_BIT 0
`define MIE_FLAG_C_BIT 0
`define MIE_FLAG_DC_BIT 1
`define MIE_FLAG_Z_BIT 2
`define MIE_STAT_RUN_BIT 0
`define MIE_STAT_FLUSH_BIT 1
`define MIE_STAT_UNSUP_BIT 2
`define MIE_STAT_PHASE_LSB 4

// reset values
`define MIE_RST_ACC 8'h00
`define MIE_RST_PC 11'h000
`define MIE_RST_WORD 14'h0000

// instruction word field positions
`define MIE_FADDR_MSB 6
`define MIE_DEST_BIT 7
`define MIE_BSEL_LSB 7
`define MIE_BSEL_MSB 9
`define MIE_K8_MSB 7
`define MIE_K11_MSB 10

// opcode masks and matches; bits outside a mask are ignored
`define MIE_MASK_ADD_LITERAL_TO_ACCUMULATOR 14'h3e00
`define MIE_MATCH_ADD_LITERAL_TO_ACCUMULATOR 14'h3e00
`define MIE_MASK_ADD_ACCUMULATOR_TO_FILE 14'h3f00
`define MIE_MATCH_ADD_ACCUMULATOR_TO_FILE 14'h0700
`define MIE_MASK_BITOP 14'h3c00
`define MIE_MATCH_BCLR 14'h1000
`define MIE_MATCH_BSET 14'h1400
`define MIE_MASK_JUMP 14'h3800
`define MIE_MATCH_JUMP 14'h2800
`define MIE_MASK_NOP 14'h3f9f
`define MIE_MATCH_NOP 14'h0000

// timing: oscillator periods (hclk cycles) in one instruction cycle
`define MIE_OSC_PER_CYCLE 4

// bus constants
`define MIE_HSIZE_WORD 3'h2

`endif

// File: mie_pkg.sv
// types shared by the instruction execute core and its alu
`default_nettype none
package mie_pkg;

  // instruction word and data byte
  typedef logic [13:0] mie_word_t;
  typedef logic [7:0] mie_byte_t;

  // the four phases of one instruction cycle, gray coded
  typedef enum logic [1:0] {
    mie_q1 = 2'b00,
    mie_q2 = 2'b01,
    mie_q3 = 2'b11,
    mie_q4 = 2'b10
  } mie_phase_e;

  // decoded operations
  typedef enum logic [2:0] {
    mie_op_nop = 3'h0,
    mie_op_add_literal_to_accumulator = 3'h1,
    mie_op_add_accumulator_to_file = 3'h2,
    mie_op_clear_file_bit = 3'h3,
    mie_op_set_file_bit = 3'h4,
    mie_op_jump = 3'h5,
    mie_op_unsupported = 3'h6
  } mie_op_e;

endpackage : mie_pkg
`default_nettype wire

// File: mie_alu.sv
// adder and bit modifier of the instruction execute core
`timescale 1ns/1ps
`default_nettype none

module mie_alu (
  // operation select
  input wire mie_pkg::mie_op_e op,
  // operands
  input wire mie_pkg::mie_byte_t acc,
  input wire mie_pkg::mie_byte_t file_data,
  input wire mie_pkg::mie_byte_t literal,
  input wire logic [2:0] bit_sel,
  // result and flags
  output mie_pkg::mie_byte_t result,
  output logic carry,
  output logic digit_carry_flag,
  output logic zero
);
  import mie_pkg::*;

  logic [8:0] sum;
  logic [4:0] nib_sum;
  mie_byte_t addend;
  mie_byte_t bit_res;
  logic is_add;
  logic is_bit;

  // operand selection
  assign is_add = (op == mie_op_add_literal_to_accumulator) ||
                  (op == mie_op_add_accumulator_to_file);
  assign is_bit = (op == mie_op_clear_file_bit) || (op == mie_op_set_file_bit);
  assign addend = (op == mie_op_add_literal_to_accumulator) ? literal : file_data;

  // 8-bit add with carry out of bit 7 and of bit 3
  assign sum = {1'b0, acc} + {1'b0, addend};
  assign nib_sum = {1'b0, acc[3:0]} + {1'b0, addend[3:0]};

  // per-bit modify of the file value, only the selected bit changes
  generate
    for (genvar i = 0; i < 8; i++) begin : g_bit
      assign bit_res[i] = (bit_sel == 3'(i)) ? (op == mie_op_set_file_bit) : file_data[i];
    end
  endgenerate

  // result and flags
  assign result = is_add ? sum[7:0] : (is_bit ? bit_res : file_data);
  assign carry = sum[8];
  assign digit_carry_flag = nib_sum[4];
  assign zero = (sum[7:0] == 8'h00);

endmodule : mie_alu

`default_nettype wire

// File: mie_core.sv
// instruction decode and execute core with ahb-lite control registers
//
// Function
// RULE1 - Each instruction is decoded as one 14-bit word of opcode and operand fields.
// RULE2 - Byte operations write the accumulator when the destination bit is 0, the file when 1.
// RULE3 - The file address operand selects one register from 0x00 to 0x7f.
// RULE4 - Bit operations use the bit select operand to pick one bit of the 8-bit file value.
// RULE5 - Literal and control operations carry an 8-bit or an 11-bit constant.
// RULE6 - An instruction cycle is four oscillator periods and plain instructions take one.
// RULE7 - A program counter change costs a second cycle that runs as a no-operation.
// RULE8 - An instruction naming a file register reads it, modifies it, then stores it.
// RULE9 - Don't-care encoding bits are ignored by the decoder whatever their value.
// RULE10 - Add literal adds an 8-bit constant to the accumulator and updates c, dc and z.
// RULE11 - Add to file adds accumulator and file, stores at the destination, updates c, dc, z.
// RULE12 - Bit clear forces the selected file bit to zero and leaves the flags alone.
// RULE13 - Bit set forces the selected file bit to one and leaves the flags alone.
// RULE14 - Opcode and operand positions follow the usual mid-range 14-bit layout.
`timescale 1ns/1ps
`default_nettype none
`include "mie_regs.svh"

module mie_core (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // program memory
  output logic [10:0] prog_addr,
  output logic prog_re,
  input wire mie_pkg::mie_word_t prog_data,
  // file register space
  output logic [6:0] file_addr,
  output logic file_re,
  input wire mie_pkg::mie_byte_t file_rdata,
  output logic file_we,
  output mie_pkg::mie_byte_t file_wdata
);
  import mie_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // decode function

  // classify one instruction word by mask and match
  function automatic mie_op_e mie_decode(input mie_word_t w);
    mie_op_e op;
    op = mie_op_unsupported;
    if ((w & `MIE_MASK_ADD_LITERAL_TO_ACCUMULATOR) == `MIE_MATCH_ADD_LITERAL_TO_ACCUMULATOR) begin
      op = mie_op_add_literal_to_accumulator;
    end else if ((w & `MIE_MASK_ADD_ACCUMULATOR_TO_FILE) == `MIE_MATCH_ADD_ACCUMULATOR_TO_FILE) begin
      op = mie_op_add_accumulator_to_file;
    end else if ((w & `MIE_MASK_BITOP) == `MIE_MATCH_BCLR) begin
      op = mie_op_clear_file_bit;
    end else if ((w & `MIE_MASK_BITOP) == `MIE_MATCH_BSET) begin
      op = mie_op_set_file_bit;
    end else if ((w & `MIE_MASK_JUMP) == `MIE_MATCH_JUMP) begin
      op = mie_op_jump;
    end else if ((w & `MIE_MASK_NOP) == `MIE_MATCH_NOP) begin
      op = mie_op_nop;
    end
    return op;
  endfunction : mie_decode

  ////////////////////////////////////////////////////////////////////////////////
  // state

  mie_phase_e phase_reg;
  mie_phase_e phase_next;
  logic run_reg;
  logic run_next;
  mie_byte_t acc_reg;
  mie_byte_t acc_next;
  logic [2:0] flags_reg;
  logic [2:0] flags_next;
  logic [10:0] pc_reg;
  logic [10:0] pc_next;
  mie_word_t instr_reg;
  mie_word_t instr_next;
  mie_byte_t fdata_reg;
  mie_byte_t result_reg;
  logic [2:0] rflags_reg;
  logic flush_reg;
  logic flush_next;
  logic unsup_reg;
  logic unsup_next;
  logic [31:0] hrdata_reg;
  logic wr_pend_reg;
  logic [7:0] wr_off_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // instruction fields and decode

  mie_op_e op;
  logic dest_file;
  logic names_file;
  logic to_file;
  logic to_acc;
  logic flags_we;
  logic is_jump;
  mie_byte_t lit8;
  logic [10:0] lit11;
  logic [2:0] bit_sel;
  mie_byte_t alu_res;
  logic alu_c;
  logic alu_dc;
  logic alu_z;

  // RULE1 whole word decode
  // RULE9 masks skip don't-cares
  // RULE14 mid-range field layout
  assign op = mie_decode(instr_reg);
  assign dest_file = instr_reg[`MIE_DEST_BIT];
  // RULE5 8 or 11-bit literals
  assign lit8 = instr_reg[`MIE_K8_MSB:0];
  assign lit11 = instr_reg[`MIE_K11_MSB:0];
  // RULE4 bit select field
  assign bit_sel = instr_reg[`MIE_BSEL_MSB:`MIE_BSEL_LSB];
  assign is_jump = (op == mie_op_jump);
  assign names_file = (op == mie_op_add_accumulator_to_file) ||
                      (op == mie_op_clear_file_bit) || (op == mie_op_set_file_bit);
  // RULE2 destination bit choice
  assign to_file = ((op == mie_op_add_accumulator_to_file) && dest_file) ||
                   (op == mie_op_clear_file_bit) || (op == mie_op_set_file_bit);
  assign to_acc = (op == mie_op_add_literal_to_accumulator) ||
                  ((op == mie_op_add_accumulator_to_file) && !dest_file);
  // RULE12 bit ops keep flags
  // RULE13 bit ops keep flags
  assign flags_we = (op == mie_op_add_literal_to_accumulator) ||
                    (op == mie_op_add_accumulator_to_file);

  // add and bit modify datapath
  mie_alu u_alu (
    .op(op),
    .acc(acc_reg),
    .file_data(fdata_reg),
    .literal(lit8),
    .bit_sel(bit_sel),
    .result(alu_res),
    .carry(alu_c),
    .digit_carry_flag(alu_dc),
    .zero(alu_z)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // ahb-lite decode

  logic bus_take;
  logic rd_take;
  logic wr_take;
  logic halted;
  logic wr_ctrl;
  logic wr_acc;
  logic wr_flags;
  logic wr_pc;
  logic wr_status;
  logic [7:0] rd_off;
  logic [31:0] rd_mux;

  // address phase acceptance, word writes only
  assign bus_take = hsel && hready && htrans[1];
  assign rd_take = bus_take && !hwrite;
  assign wr_take = bus_take && hwrite && (hsize == `MIE_HSIZE_WORD);
  assign rd_off = {haddr[7:2], 2'b00};

  // data phase write strobes; acc, flags and pc writable only while halted, control and status at any time
  assign halted = (phase_reg == mie_q1) && !run_reg;
  assign wr_ctrl = wr_pend_reg && (wr_off_reg == `MIE_OFF_CTRL);
  assign wr_acc = wr_pend_reg && (wr_off_reg == `MIE_OFF_ACC) && halted;
  assign wr_flags = wr_pend_reg && (wr_off_reg == `MIE_OFF_FLAGS) && halted;
  assign wr_pc = wr_pend_reg && (wr_off_reg == `MIE_OFF_PC) && halted;
  assign wr_status = wr_pend_reg && (wr_off_reg == `MIE_OFF_STATUS);

  // read mux from next values so a read right after a write sees it
  assign rd_mux =
    (rd_off == `MIE_OFF_CTRL) ? {31'h0, run_next} :
    (rd_off == `MIE_OFF_ACC) ? {24'h0, acc_next} :
    (rd_off == `MIE_OFF_FLAGS) ? {29'h0, flags_next} :
    (rd_off == `MIE_OFF_PC) ? {21'h0, pc_next} :
    (rd_off == `MIE_OFF_INSTR) ? {18'h0, instr_next} :
    (rd_off == `MIE_OFF_STATUS) ? {26'h0, phase_next, 1'b0, unsup_next, flush_next, run_next} :
    32'h0;

  // zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // phase sequencing and next state

  logic adv;
  logic end_q1;
  logic end_q2;
  logic end_q3;
  logic end_q4;
  logic exec;

  // RULE6 four phases per cycle
  assign adv = run_reg || (phase_reg != mie_q1);
  assign end_q1 = adv && (phase_reg == mie_q1);
  assign end_q2 = (phase_reg == mie_q2);
  assign end_q3 = (phase_reg == mie_q3);
  assign end_q4 = (phase_reg == mie_q4);
  assign exec = !flush_reg;

  // gray phase stepping
  always_comb begin
    case (phase_reg)
      mie_q1: phase_next = adv ? mie_q2 : mie_q1;
      mie_q2: phase_next = mie_q3;
      mie_q3: phase_next = mie_q4;
      mie_q4: phase_next = mie_q1;
      default: phase_next = mie_q1;
    endcase
  end

  // RULE7 flushed cycle loads a no-op word without fetching
  assign instr_next = end_q1 ? (exec ? prog_data : `MIE_RST_WORD) : instr_reg;
  assign flush_next = end_q4 ? (exec && is_jump) : flush_reg;

  // RULE7 jump loads pc, flushed cycle holds it
  assign pc_next = wr_pc ? hwdata[10:0] :
                   (end_q4 && exec) ? (is_jump ? lit11 : 11'(pc_reg + 11'h001)) : pc_reg;

  // RULE10 literal sum into accumulator
  // RULE11 sum to chosen destination
  assign acc_next = wr_acc ? hwdata[7:0] : (end_q4 && exec && to_acc) ? result_reg : acc_reg;
  assign flags_next = wr_flags ? hwdata[2:0] :
                      (end_q4 && exec && flags_we) ? rflags_reg : flags_reg;
  assign run_next = wr_ctrl ? hwdata[`MIE_CTRL_RUN_BIT] : run_reg;

  // sticky unsupported flag, a new event wins over the clear
  assign unsup_next = (end_q4 && exec && (op == mie_op_unsupported)) ? 1'b1 :
                      (wr_status && hwdata[`MIE_STAT_UNSUP_BIT]) ? 1'b0 : unsup_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // memory strobes

  // instruction fetch in the first phase
  assign prog_addr = pc_reg;
  assign prog_re = (phase_reg == mie_q1) && run_reg && exec;

  // RULE3 7-bit file address
  assign file_addr = instr_reg[`MIE_FADDR_MSB:0];
  // RULE8 read before every file store
  assign file_re = (phase_reg == mie_q2) && exec && names_file;
  assign file_we = (phase_reg == mie_q4) && exec && to_file;
  assign file_wdata = result_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // core registers

  // phase, control and architectural state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_reg <= mie_q1;
      run_reg <= 1'b0;
      acc_reg <= `MIE_RST_ACC;
      flags_reg <= 3'h0;
      pc_reg <= `MIE_RST_PC;
      instr_reg <= `MIE_RST_WORD;
      flush_reg <= 1'b0;
      unsup_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      run_reg <= run_next;
      acc_reg <= acc_next;
      flags_reg <= flags_next;
      pc_reg <= pc_next;
      instr_reg <= instr_next;
      flush_reg <= flush_next;
      unsup_reg <= unsup_next;
    end
  end

  // RULE8 file value captured, then modified
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fdata_reg <= 8'h00;
    end else if (end_q2 && exec && names_file) begin
      fdata_reg <= file_rdata;
    end
  end

  // result and flag staging in the third phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_reg <= 8'h00;
      rflags_reg <= 3'h0;
    end else if (end_q3) begin
      result_reg <= alu_res;
      rflags_reg <= {alu_z, alu_dc, alu_c};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bus registers

  // pending write and read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_off_reg <= 8'h00;
      hrdata_reg <= 32'h0;
    end else begin
      wr_pend_reg <= wr_take;
      wr_off_reg <= {haddr[7:2], 2'b00};
      hrdata_reg <= rd_take ? rd_mux : hrdata_reg;
    end
  end

endmodule : mie_core

`default_nettype wire

// File: mie_assertions.sv
// concurrent checks on the execute core ports
`timescale 1ns/1ps
`default_nettype none
`include "mie_regs.svh"
module mie_assertions (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // program memory
  input wire logic prog_re,
  input wire mie_pkg::mie_word_t prog_data,
  // file space
  input wire logic [6:0] file_addr,
  input wire logic file_re,
  input wire mie_pkg::mie_byte_t file_rdata,
  input wire logic file_we,
  input wire mie_pkg::mie_byte_t file_wdata
);
  import mie_pkg::*;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  mie_word_t word_reg;
  mie_byte_t rd_reg;
  logic is_jump, is_add_literal_to_accumulator, is_add_accumulator_to_file, is_fileop, q_bset, q_bclr;
  // decode of fetched and latched words
  assign is_jump = (prog_data & `MIE_MASK_JUMP) == `MIE_MATCH_JUMP;
  assign is_add_literal_to_accumulator = (prog_data & `MIE_MASK_ADD_LITERAL_TO_ACCUMULATOR) == `MIE_MATCH_ADD_LITERAL_TO_ACCUMULATOR;
  assign is_add_accumulator_to_file = (prog_data & `MIE_MASK_ADD_ACCUMULATOR_TO_FILE) == `MIE_MATCH_ADD_ACCUMULATOR_TO_FILE;
  assign is_fileop = is_add_accumulator_to_file || (prog_data[13:12] == 2'h1);
  assign q_bset = (word_reg & `MIE_MASK_BITOP) == `MIE_MATCH_BSET;
  assign q_bclr = (word_reg & `MIE_MASK_BITOP) == `MIE_MATCH_BCLR;
  // latch fetched word and file read value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      word_reg <= 14'h0000;
      rd_reg <= 8'h00;
    end else begin
      if (prog_re) word_reg <= prog_data;
      if (file_re) rd_reg <= file_rdata;
    end
  end
  fetch_once_a: assert property (prog_re |=> !prog_re [*3])
    else $error("fetch repeated within one cycle");
  jump_idle_a: assert property (prog_re && is_jump |=>
    (!prog_re && !file_re && !file_we) [*7]) else $error("jump second cycle not idle");
  rmw_order_a: assert property (file_we |->
    $past(file_re, 2) && file_addr == $past(file_addr, 2)) else $error("store without read");
  file_addr_a: assert property (prog_re && is_fileop |=>
    file_re && file_addr == word_reg[6:0]) else $error("file address not from word");
  dest_acc_a: assert property (prog_re && is_add_accumulator_to_file && !prog_data[7]
    |=> !file_we [*3]) else $error("accumulator result written to file");
  dest_file_a: assert property (prog_re && is_add_accumulator_to_file && prog_data[7]
    |-> ##3 file_we) else $error("file result not stored");
  lit_nofile_a: assert property (prog_re && is_add_literal_to_accumulator |=>
    (!file_re && !file_we) [*3]) else $error("literal add touched file");
  bit_set_a: assert property (file_we && q_bset |->
    file_wdata == (rd_reg | (8'h01 << word_reg[9:7]))) else $error("bit set value wrong");
  bit_clear_a: assert property (file_we && q_bclr |->
    file_wdata == (rd_reg & ~(8'h01 << word_reg[9:7]))) else $error("bit clear value wrong");
  // main scenarios seen
  cover property (prog_re && is_jump);
  cover property (file_we && q_bset);
  cover property (file_we && q_bclr);
endmodule : mie_assertions
`default_nettype wire

// File: mie_mem_model.sv
// program memory and file register space facing the core
`timescale 1ns/1ps
`default_nettype none
module mie_mem_model (
  // clock
  input wire logic hclk,
  // program memory
  input wire logic [10:0] prog_addr,
  input wire logic prog_re,
  output mie_pkg::mie_word_t prog_data,
  // file space
  input wire logic [6:0] file_addr,
  input wire logic file_re,
  output mie_pkg::mie_byte_t file_rdata,
  input wire logic file_we,
  input wire mie_pkg::mie_byte_t file_wdata
);
  import mie_pkg::*;
  mie_word_t pmem [0:2047];
  mie_byte_t fmem [0:127];
  // whole word, scrambled when not fetched
  assign prog_data = prog_re ? pmem[prog_addr] : ~pmem[prog_addr];
  // read data valid only under strobe
  assign file_rdata = file_re ? fmem[file_addr] : ~fmem[file_addr];
  always @(posedge hclk) begin
    if (file_we) fmem[file_addr] <= file_wdata;
  end
endmodule : mie_mem_model
`default_nettype wire

// File: mcu_instruction_execute_bench.sv
// self-checking bench for the instruction execute core
`timescale 1ns/1ps
`default_nettype none
`include "mie_regs.svh"
module mcu_instruction_execute_bench;
  import mie_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, prog_re, file_re, file_we;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [10:0] prog_addr;
  logic [6:0] file_addr;
  mie_word_t prog_data;
  mie_byte_t file_rdata, file_wdata;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  int ftime [0:15];

  // core and memory partner
  mie_core u_mie_core (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .prog_addr, .prog_re,
    .prog_data, .file_addr, .file_re, .file_rdata, .file_we, .file_wdata);
  mie_mem_model u_mie_mem_model (.hclk, .prog_addr, .prog_re, .prog_data,
    .file_addr, .file_re, .file_rdata, .file_we, .file_wdata);

  // clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // cycle count, first fetch times, hang guard
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (prog_re && prog_addr < 11'h010 && ftime[prog_addr[3:0]] < 0) ftime[prog_addr[3:0]] <= cyc;
    if (cyc == 3000) begin
      n_mismatch++;
      summarize();
    end
  end

  // compare and count
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one single ahb-lite transfer
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : ahb

  // read and compare
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h00000000);
    chk(what, exp, rd);
  endtask : rdc

  // reset values, halted writes, unmapped word
  task automatic test_regs();
    rdc("acc reset", `MIE_OFF_ACC, 32'h00000000);
    rdc("pc reset", `MIE_OFF_PC, 32'h00000000);
    ahb(1'b1, `MIE_OFF_ACC, 32'h000000a5);
    rdc("acc write", `MIE_OFF_ACC, 32'h000000a5);
    ahb(1'b1, `MIE_OFF_FLAGS, 32'h00000007);
    rdc("flags write", `MIE_OFF_FLAGS, 32'h00000007);
    ahb(1'b1, 8'h1c, 32'hffffffff);
    rdc("unmapped", 8'h1c, 32'h00000000);
    $display("test_regs done");
  endtask : test_regs

  // program of add, bit and jump steps
  task automatic test_program();
    u_mie_mem_model.fmem[7'h7f] = 8'hf1;
    u_mie_mem_model.fmem[7'h06] = 8'hff;
    u_mie_mem_model.fmem[7'h05] = 8'h00;
    u_mie_mem_model.pmem[0] = 14'h3f0f; // literal add 0x0f, loose bit set
    u_mie_mem_model.pmem[1] = 14'h0706; // add file 0x06 to acc
    u_mie_mem_model.pmem[2] = 14'h07ff; // add acc into file 0x7f
    u_mie_mem_model.pmem[3] = 14'h1785; // set bit 7 of 0x05
    u_mie_mem_model.pmem[4] = 14'h1006; // clear bit 0 of 0x06
    u_mie_mem_model.pmem[5] = 14'h2807; // jump to 7
    u_mie_mem_model.pmem[6] = 14'h3e01; // skipped
    u_mie_mem_model.pmem[7] = 14'h0060; // no-op, loose bits set
    u_mie_mem_model.pmem[8] = 14'h2808; // jump to self
    ahb(1'b1, `MIE_OFF_ACC, 32'h00000001);
    ahb(1'b1, `MIE_OFF_FLAGS, 32'h00000000);
    ahb(1'b1, `MIE_OFF_PC, 32'h00000000);
    ahb(1'b1, `MIE_OFF_CTRL, 32'h00000001);
    repeat (60) @(posedge hclk);
    ahb(1'b1, `MIE_OFF_CTRL, 32'h00000000);
    repeat (8) @(posedge hclk);
    rdc("pc end", `MIE_OFF_PC, 32'h00000008);
    rdc("acc end", `MIE_OFF_ACC, 32'h0000000f);
    rdc("flags end", `MIE_OFF_FLAGS, 32'h00000007);
    chk("file 7f", 32'h00000000, {24'h000000, u_mie_mem_model.fmem[7'h7f]});
    chk("file 05", 32'h00000080, {24'h000000, u_mie_mem_model.fmem[7'h05]});
    chk("file 06", 32'h000000fe, {24'h000000, u_mie_mem_model.fmem[7'h06]});
    chk("fetch gap", 32'h00000004, 32'(ftime[1] - ftime[0]));
    chk("five fetches", 32'h00000014, 32'(ftime[5] - ftime[0]));
    chk("jump gap", 32'h00000008, 32'(ftime[7] - ftime[5]));
    chk("skipped word", 32'hffffffff, 32'(ftime[6]));
    chk("nop gap", 32'h00000004, 32'(ftime[8] - ftime[7]));
    $display("test_program done");
  endtask : test_program

  // refused writes and the sticky flag for words outside the decoded set
  task automatic test_refuse();
    u_mie_mem_model.pmem[9] = 14'h0900; // not a decoded operation
    u_mie_mem_model.pmem[10] = 14'h280a; // jump to self
    hsize <= 3'h0;
    ahb(1'b1, `MIE_OFF_ACC, 32'h00000033);
    hsize <= `MIE_HSIZE_WORD;
    rdc("byte write", `MIE_OFF_ACC, 32'h0000000f);
    ahb(1'b1, `MIE_OFF_PC, 32'h00000009);
    ahb(1'b1, `MIE_OFF_CTRL, 32'h00000001);
    ahb(1'b1, `MIE_OFF_ACC, 32'h00000055);
    repeat (24) @(posedge hclk);
    ahb(1'b1, `MIE_OFF_CTRL, 32'h00000000);
    repeat (8) @(posedge hclk);
    rdc("pc after skip", `MIE_OFF_PC, 32'h0000000a);
    rdc("acc kept", `MIE_OFF_ACC, 32'h0000000f);
    ahb(1'b0, `MIE_OFF_STATUS, 32'h00000000);
    chk("unsupported set", 32'h00000004, rd & 32'h00000035);
    ahb(1'b1, `MIE_OFF_STATUS, 32'h00000004);
    ahb(1'b0, `MIE_OFF_STATUS, 32'h00000000);
    chk("unsupported cleared", 32'h00000000, rd & 32'h00000035);
    $display("test_refuse done");
  endtask : test_refuse

  // counts and verdict
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize

  // reset then scenarios
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = `MIE_HSIZE_WORD;
    hwdata = 32'h00000000;
    foreach (ftime[i]) ftime[i] = -1;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    test_regs();
    test_program();
    test_refuse();
    summarize();
  end
endmodule : mcu_instruction_execute_bench

bind mie_core mie_assertions u_mie_assertions (.hclk, .hresetn, .prog_re, .prog_data,
  .file_addr, .file_re, .file_rdata, .file_we, .file_wdata);
`default_nettype wire
